// ===== shared/ahrs_defines.svh
// Constants for the asynchronous hardware reset sequencer.
// Assumes a 125 MHz CPU clock; included by the package and the design file.
`ifndef AHRS_DEFINES_SVH
`define AHRS_DEFINES_SVH

// Clock period in picoseconds and the reset input filter time in nanoseconds.
`define AHRS_CLK_PS 8000
`define AHRS_FILTER_NS 500
// Least filter time rounded up to whole clock cycles.
`define AHRS_FILTER_CYC ((`AHRS_FILTER_NS * 1000 + `AHRS_CLK_PS - 1) / `AHRS_CLK_PS)
// Release window for external boot, in half clock periods.
`define AHRS_EXT_TCL_MIN 3
`define AHRS_EXT_TCL_MAX 8
// Cycles during which early flash reads return all ones.
`define AHRS_FLASH_EARLY_CYC 16
`define AHRS_FLASH_EARLY_DATA 16'hffff
`define AHRS_FLASH_LATE_DATA 16'h009b
// Start of instruction fetch after release.
`define AHRS_FETCH_ADDR 24'h000000
`define AHRS_FETCH_SEG 8'h00
// Configuration port width and clock option field position.
`define AHRS_CFG_W 16
`define AHRS_CLK_OPT_HI 15
`define AHRS_CLK_OPT_LO 13
// Value of the configuration port while its pins are pulled high.
`define AHRS_CFG_PULLED 16'hffff

`endif

// ===== shared/ahrs_pkg.sv
// Types shared by the reset sequencer and its bench.
// Assumes the constants header sits in the include path.
`include "ahrs_defines.svh"

package ahrs_pkg;

    // Sequencer states, Gray coded along reset, wait, run.
    typedef enum logic [1:0]
    {
        AHRS_ST_RESET = 2'b00,
        AHRS_ST_WAIT = 2'b01,
        AHRS_ST_RUN = 2'b11,
        AHRS_ST_WARM = 2'b10
    } ahrs_state_e;

    // External bus strobe levels: address latch high active, read and write low active.
    typedef struct packed
    {
        logic ale;
        logic rd_n;
        logic write_strobe_n;
    } ahrs_strobe_s;

    // Pins that pass the three stage synchroniser together.
    typedef struct packed
    {
        logic reset_in_pin_n;
        logic reset_kind_select_pin;
        logic external_access_select;
        logic [`AHRS_CFG_W-1:0] configuration_port;
    } ahrs_pins_s;

endpackage : ahrs_pkg

// ===== design/ahrs_sequencer.sv
// Asynchronous hardware and power-on reset sequencer of a 16-bit controller.
// Assumes resetn_i comes from an on-chip power detector and works with no clock,
// and that the flash controller reports the end of its initialisation on clk_i.
// Contract
// [RULE1] Low reset pin with low kind pin: asynchronous reset.
// [RULE2] Kind pin high: warm reset instead.
// [RULE3] After filter delay, default state, reset out low.
// [RULE4] Entry cancels holds, aborts bus cycles.
// [RULE5] Buses and pins float, configuration port pulled high.
// [RULE6] Detection needs no running clock; here only resetn_i does, the reset pin is sampled on clk_i.
// [RULE7] Partner holds both pins low until settled.
// [RULE8] Partner extends reset for regulator, one millisecond.
// [RULE9] Flash boot: hold reset until flash ready.
// [RULE10] External boot: release after three to eight half-clocks.
// [RULE11] Early flash reads: all ones, then 009B.
// [RULE12] Partner covers oscillator and PLL start-up.
// [RULE13] Partner pulses exceed filter and PLL relock.
// [RULE14] Latch configuration port when reset pin rises.
// [RULE15] Strobes inactive on leaving reset.
// [RULE16] Fetch starts at address zero, segment zero.
// [RULE17] Partner prefers synchronous reset.
// [RULE18] Glitch filter drops pulses shorter than delay.
// [RULE19] Internal reset asserts async, releases synchronously; here only power-on asserts async, the pin path asserts on a clock edge.
`timescale 1ns/10ps
`include "ahrs_defines.svh"

module ahrs_sequencer
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic reset_in_pin_n_i,
    input wire logic reset_kind_select_pin_i,
    input wire logic external_access_select_i,
    input wire logic [`AHRS_CFG_W-1:0] configuration_port_i,
    input wire logic flash_init_done_i,
    input wire logic [15:0] flash_rdata_i,
    output logic core_reset_n_o,
    output logic reset_out_pin_n_o,
    output logic warm_reset_o,
    output logic hold_cancel_o,
    output logic bus_abort_o,
    output logic bus_hiz_o,
    output logic config_pullup_o,
    output logic [`AHRS_CFG_W-1:0] config_latched_o,
    output ahrs_pkg::ahrs_strobe_s strobes_o,
    output logic fetch_start_o,
    output logic [23:0] fetch_addr_o,
    output logic [7:0] fetch_seg_o,
    output logic [15:0] flash_rdata_o
);
    import ahrs_pkg::*;

    localparam logic [7:0] FILTER_CYC = 8'(`AHRS_FILTER_CYC);

    // Clock-cycle count for external boot release: the half-clock count from the clock option bits, halved and rounded up.
    function automatic logic [3:0] ext_release_cyc(input logic [2:0] opt);
        logic [3:0] half_clock_period;
        half_clock_period = 4'(`AHRS_EXT_TCL_MIN) + {1'b0, opt};
        if (half_clock_period > 4'(`AHRS_EXT_TCL_MAX))
        begin
            half_clock_period = 4'(`AHRS_EXT_TCL_MAX);
        end
        ext_release_cyc = (half_clock_period + 4'h1) >> 1;
    endfunction : ext_release_cyc

    ahrs_pins_s pins_s1_r;
    ahrs_pins_s pins_s2_r;
    ahrs_pins_s pins_s3_r;
    ahrs_pins_s pins_r;
    ahrs_pins_s pins_nxt;
    ahrs_state_e state_r;
    ahrs_state_e state_nxt;
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;
    logic [3:0] rel_cnt_r;
    logic [3:0] rel_cnt_nxt;
    logic [4:0] early_cnt_r;
    logic [`AHRS_CFG_W-1:0] cfg_r;
    logic core_reset_n_r;
    logic out_n_r;
    logic warm_r;
    logic hiz_r;
    logic fetch_r;
    ahrs_strobe_s strobes_r;
    logic [15:0] rdata_r;

    // Three stage synchroniser on every pin; the first stage feeds only the second.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pins_s1_r <= '1;
            pins_s2_r <= '1;
            pins_s3_r <= '1;
            pins_r <= '1;
        end
        else if (ce_i)
        begin
            pins_s1_r <= {reset_in_pin_n_i, reset_kind_select_pin_i, external_access_select_i, configuration_port_i};
            pins_s2_r <= pins_s1_r;
            pins_s3_r <= pins_s2_r;
            pins_r <= pins_nxt;
        end
    end

    // A pin bit is taken only once stages two and three agree.
    assign pins_nxt = (pins_r & (pins_s2_r ^ pins_s3_r)) | (pins_s2_r & ~(pins_s2_r ^ pins_s3_r));

    // Glitch filter: a low shorter than the filter time never reaches the trigger.
    // [RULE18] glitch filter count
    wire pin_low = !pins_r.reset_in_pin_n;
    assign low_cnt_nxt = !pin_low ? 8'h00 : (low_cnt_r == FILTER_CYC) ? low_cnt_r : low_cnt_r + 8'h01;
    wire trig = pin_low && (low_cnt_nxt == FILTER_CYC) && (low_cnt_r != FILTER_CYC);
    wire pin_rise = pins_r.reset_in_pin_n;
    wire [2:0] clk_opt = pins_r.configuration_port[`AHRS_CLK_OPT_HI:`AHRS_CLK_OPT_LO];

    // Next state: the kind pin chooses between the full and the warm sequence.
    always_comb
    begin
        state_nxt = state_r;
        rel_cnt_nxt = rel_cnt_r;
        case (state_r)
            AHRS_ST_RUN:
            begin
                // [RULE1] asynchronous kind select
                if (trig && !pins_r.reset_kind_select_pin)
                begin
                    state_nxt = AHRS_ST_RESET;
                end
                // [RULE2] warm reset path
                else if (trig)
                begin
                    state_nxt = AHRS_ST_WARM;
                end
            end
            AHRS_ST_RESET:
            begin
                if (pin_rise)
                begin
                    state_nxt = AHRS_ST_WAIT;
                    rel_cnt_nxt = ext_release_cyc(clk_opt);
                end
            end
            AHRS_ST_WAIT:
            begin
                if (pin_low)
                begin
                    state_nxt = AHRS_ST_RESET;
                end
                // [RULE10] external boot release
                else if (!pins_r.external_access_select)
                begin
                    rel_cnt_nxt = rel_cnt_r - 4'h1;
                    if (rel_cnt_r == 4'h1)
                    begin
                        state_nxt = AHRS_ST_RUN;
                    end
                end
                // [RULE9] wait for flash ready
                else if (flash_init_done_i)
                begin
                    state_nxt = AHRS_ST_RUN;
                end
            end
            AHRS_ST_WARM:
            begin
                if (pin_rise)
                begin
                    state_nxt = AHRS_ST_RUN;
                end
            end
            default:
            begin
                state_nxt = AHRS_ST_RESET;
            end
        endcase
    end

    wire in_reset_nxt = (state_nxt == AHRS_ST_RESET) || (state_nxt == AHRS_ST_WAIT);

    // Power-on reset clears everything with no clock; the pin path asserts
    // after the filter and every release is taken on a clock edge.
    // [RULE6] clockless power-on detection
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r <= AHRS_ST_RESET;
            low_cnt_r <= 8'h00;
            rel_cnt_r <= 4'h0;
            core_reset_n_r <= 1'b0;
            out_n_r <= 1'b0;
            warm_r <= 1'b0;
            hiz_r <= 1'b1;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            low_cnt_r <= low_cnt_nxt;
            rel_cnt_r <= rel_cnt_nxt;
            // [RULE19] synchronous release
            core_reset_n_r <= (state_nxt == AHRS_ST_RUN);
            // [RULE3] reset out driven low
            out_n_r <= !in_reset_nxt && (state_nxt != AHRS_ST_WARM);
            warm_r <= (state_nxt == AHRS_ST_WARM);
            // [RULE5] buses float in reset
            hiz_r <= in_reset_nxt || (state_nxt == AHRS_ST_WARM);
        end
    end

    // Configuration capture on the pin rise in the reset state, idle strobes while in reset, fetch start on release from the wait state.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_r <= `AHRS_CFG_PULLED;
            strobes_r <= '{ale: 1'b0, rd_n: 1'b1, write_strobe_n: 1'b1};
            fetch_r <= 1'b0;
        end
        else if (ce_i)
        begin
            // [RULE14] latch configuration port
            if (state_r == AHRS_ST_RESET && pin_rise)
            begin
                cfg_r <= pins_r.configuration_port;
            end
            // [RULE15] strobes driven inactive
            if (in_reset_nxt)
            begin
                strobes_r <= '{ale: 1'b0, rd_n: 1'b1, write_strobe_n: 1'b1};
            end
            // [RULE16] fetch from address zero
            fetch_r <= (state_r == AHRS_ST_WAIT) && (state_nxt == AHRS_ST_RUN);
        end
    end

    // Flash data before initialisation ends: all ones first, then the fixed
    // opcode that traps; software must not rely on either value.
    // [RULE11] early flash read data
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            early_cnt_r <= 5'h00;
            rdata_r <= `AHRS_FLASH_EARLY_DATA;
        end
        else if (ce_i)
        begin
            if (state_nxt == AHRS_ST_RESET)
            begin
                early_cnt_r <= 5'h00;
            end
            else if (early_cnt_r != 5'(`AHRS_FLASH_EARLY_CYC))
            begin
                early_cnt_r <= early_cnt_r + 5'h01;
            end
            rdata_r <= (state_nxt == AHRS_ST_RESET) ? `AHRS_FLASH_EARLY_DATA : flash_init_done_i ? flash_rdata_i :
                (early_cnt_r != 5'(`AHRS_FLASH_EARLY_CYC)) ? `AHRS_FLASH_EARLY_DATA : `AHRS_FLASH_LATE_DATA;
        end
    end

    // [RULE4] cancel holds and abort cycles
    assign hold_cancel_o = hiz_r;
    assign bus_abort_o = hiz_r;
    assign core_reset_n_o = core_reset_n_r;
    assign reset_out_pin_n_o = out_n_r;
    assign warm_reset_o = warm_r;
    assign bus_hiz_o = hiz_r;
    assign config_pullup_o = hiz_r;
    assign config_latched_o = cfg_r;
    assign strobes_o = strobes_r;
    assign fetch_start_o = fetch_r;
    assign fetch_addr_o = `AHRS_FETCH_ADDR;
    assign fetch_seg_o = `AHRS_FETCH_SEG;
    assign flash_rdata_o = rdata_r;

    // Checks on the sequence.
    chk_async_entry: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
        (ce_i && state_r == AHRS_ST_RUN && trig && !pins_r.reset_kind_select_pin) |=> !reset_out_pin_n_o && !core_reset_n_o)
        else $error("Async reset not entered.");
    chk_warm_path: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE2
        (ce_i && state_r == AHRS_ST_RUN && trig && pins_r.reset_kind_select_pin) |=> warm_reset_o && state_r != AHRS_ST_RESET)
        else $error("Warm reset path wrong.");
    chk_out_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        (state_r == AHRS_ST_RESET) |-> !reset_out_pin_n_o && bus_abort_o)
        else $error("Reset out not low in reset.");
    chk_pins_float: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
        (!core_reset_n_o && !warm_reset_o && state_r != AHRS_ST_RUN) |-> bus_hiz_o && config_pullup_o)
        else $error("Pins not floating in reset.");
    chk_flash_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE9
        (state_r == AHRS_ST_WAIT && pins_r.external_access_select && !flash_init_done_i) |=> !core_reset_n_o)
        else $error("Released before flash ready.");
    chk_ext_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE10
        ($rose(state_r == AHRS_ST_WAIT) && !pins_r.external_access_select && ce_i) |-> ##[1:4] (state_r != AHRS_ST_WAIT))
        else $error("External boot release late.");
    chk_glitch_drop: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE18
        (state_r == AHRS_ST_RUN && low_cnt_r < FILTER_CYC - 8'h01) |=> state_r == AHRS_ST_RUN)
        else $error("Short pulse caused reset.");
    chk_cfg_capture: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE14
        (ce_i && state_r == AHRS_ST_RESET && pin_rise) |=> config_latched_o == $past(pins_r.configuration_port))
        else $error("Configuration not latched.");
    chk_fetch_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE16
        fetch_start_o |-> core_reset_n_o && fetch_addr_o == 24'h000000 && !$past(core_reset_n_o))
        else $error("Fetch start misplaced.");
    chk_strobe_idle: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE15
        (state_r == AHRS_ST_WAIT) |-> !strobes_o.ale && strobes_o.rd_n && strobes_o.write_strobe_n)
        else $error("Strobes active on reset exit.");
    chk_flash_early: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
        (state_r == AHRS_ST_RESET) |-> flash_rdata_o == 16'hffff)
        else $error("Flash data not all ones in reset.");

endmodule : ahrs_sequencer

// ===== verification/ahrs_board_model.sv
// Board model: the external reset circuit and regulator that drive the reset pins.
// Assumes the bench calls its tasks on the falling clock edge.
`timescale 1ns/10ps
`include "ahrs_defines.svh"

module ahrs_board_model
#(
    // Stands in for regulator and oscillator settle time, shortened to keep the run brief.
    parameter int REG_SETTLE_CYC = 150
)
(
    input wire logic clk_i,
    input wire logic config_pullup_i,
    output logic reset_in_pin_n_o,
    output logic reset_kind_select_pin_o,
    output logic external_access_select_o,
    output logic [`AHRS_CFG_W-1:0] configuration_port_o
);
    logic [`AHRS_CFG_W-1:0] cfg_r;
    logic cfg_on_r;

    // Undriven straps follow the pull-ups, else show a changed value so nothing stale passes.
    assign configuration_port_o = cfg_on_r ? cfg_r : (config_pullup_i ? `AHRS_CFG_PULLED : ~cfg_r);

    initial
    begin
        reset_in_pin_n_o = 1'b0;
        reset_kind_select_pin_o = 1'b0;
        external_access_select_o = 1'b0;
        cfg_r = `AHRS_CFG_PULLED;
        cfg_on_r = 1'b0;
    end

    task automatic power_up(input logic [`AHRS_CFG_W-1:0] cfg);
        repeat (REG_SETTLE_CYC) @(negedge clk_i);
        cfg_r = cfg;
        cfg_on_r = 1'b1;
        repeat (REG_SETTLE_CYC) @(negedge clk_i);
        reset_in_pin_n_o = 1'b1;
    endtask : power_up

    task automatic pin_low(input logic kind, input logic ea, input logic [`AHRS_CFG_W-1:0] cfg);
        reset_kind_select_pin_o = kind;
        external_access_select_o = ea;
        cfg_r = cfg;
        cfg_on_r = 1'b1;
        reset_in_pin_n_o = 1'b0;
    endtask : pin_low

    task automatic pin_high;
        reset_in_pin_n_o = 1'b1;
    endtask : pin_high
endmodule : ahrs_board_model

// ===== verification/async_hw_reset_sequencer_test.sv
// Self-checking bench for the reset sequencer: power-on, glitches, async, warm and flash boot.
// Assumes the board model drives the pins and the bench stands in for the flash controller.
`timescale 1ns/10ps
`include "ahrs_defines.svh"

module async_hw_reset_sequencer_test;
    import ahrs_pkg::*;
    logic clk_i = 1'b0, clk_run = 1'b0, resetn_i = 1'b1, ce_i = 1'b1, flash_init_done_i = 1'b0, saw_low = 1'b0;
    logic rst_pin_n, kind_pin, ea_pin, core_reset_n_o, reset_out_pin_n_o, warm_reset_o, hold_cancel_o;
    logic bus_abort_o, bus_hiz_o, config_pullup_o, fetch_start_o;
    logic [15:0] flash_rdata_i = 16'h0000, flash_rdata_o;
    logic [`AHRS_CFG_W-1:0] cfg_pins, config_latched_o;
    logic [23:0] fetch_addr_o;
    logic [7:0] fetch_seg_o;
    ahrs_strobe_s strobes_o;
    int n_fail = 0, checked = 0;

    // The clock can be held still to show reset works without it.
    always #4 clk_i = clk_run ? ~clk_i : clk_i;
    always @(posedge clk_i) if (reset_out_pin_n_o === 1'b0) saw_low = 1'b1;

    ahrs_board_model #(.REG_SETTLE_CYC(150)) brd (.clk_i(clk_i), .config_pullup_i(config_pullup_o),
        .reset_in_pin_n_o(rst_pin_n), .reset_kind_select_pin_o(kind_pin),
        .external_access_select_o(ea_pin), .configuration_port_o(cfg_pins));

    ahrs_sequencer dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reset_in_pin_n_i(rst_pin_n),
        .reset_kind_select_pin_i(kind_pin), .external_access_select_i(ea_pin),
        .configuration_port_i(cfg_pins), .flash_init_done_i(flash_init_done_i), .flash_rdata_i(flash_rdata_i),
        .core_reset_n_o(core_reset_n_o), .reset_out_pin_n_o(reset_out_pin_n_o), .warm_reset_o(warm_reset_o),
        .hold_cancel_o(hold_cancel_o), .bus_abort_o(bus_abort_o), .bus_hiz_o(bus_hiz_o),
        .config_pullup_o(config_pullup_o), .config_latched_o(config_latched_o), .strobes_o(strobes_o),
        .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o), .fetch_seg_o(fetch_seg_o),
        .flash_rdata_o(flash_rdata_o));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Release delay in cycles for external boot, from the clock option bits.
    function automatic int rel_cyc(input logic [2:0] opt);
        int half_clock_period;
        half_clock_period = (3 + opt > 8) ? 8 : 3 + opt;
        return (half_clock_period + 1) / 2;
    endfunction : rel_cyc

    task automatic wait_core(output int n);
        n = 0;
        while (core_reset_n_o !== 1'b1 && n < 300)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_core

    // One filtered reset pulse of len cycles, checked on entry and on exit.
    task automatic reset_case(input logic kind, input logic ea, input logic [15:0] cfg, input int len);
        int n;
        n = 0;
        flash_init_done_i = 1'b0;
        brd.pin_low(kind, ea, cfg);
        while (reset_out_pin_n_o !== 1'b0 && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        check("entry_not_early", n >= `AHRS_FILTER_CYC, 1);
        check("entry_prompt", n <= `AHRS_FILTER_CYC + 8, 1);
        check("core_reset", core_reset_n_o, 0);
        check("warm_flag", warm_reset_o, kind);
        if (!kind)
        begin
            check("abort_hiz_pullup", {hold_cancel_o, bus_abort_o, bus_hiz_o, config_pullup_o}, 4'hf);
            check("flash_early", flash_rdata_o, `AHRS_FLASH_EARLY_DATA);
        end
        repeat (len - n) @(negedge clk_i);
        brd.pin_high();
        if (ea && !kind)
        begin
            repeat (40) @(negedge clk_i);
            check("flash_hold", core_reset_n_o, 0);
            check("flash_late", flash_rdata_o, `AHRS_FLASH_LATE_DATA);
            flash_rdata_i = 16'($urandom);
            flash_init_done_i = 1'b1;
        end
        wait_core(n);
        if (!kind)
        begin
            if (ea)
                check("flash_release", n <= 2, 1);
            else
                check("ext_release", n >= rel_cyc(cfg[15:13]) + 3 && n <= rel_cyc(cfg[15:13]) + 7, 1);
            check("fetch_start", fetch_start_o, 1);
            check("fetch_addr", {fetch_seg_o, fetch_addr_o}, 0);
            check("config_latch", config_latched_o, cfg);
            check("strobes", strobes_o, 3'b011);
            check("bus_on", {bus_hiz_o, reset_out_pin_n_o}, 2'b01);
            if (ea)
                check("flash_pass", flash_rdata_o, flash_rdata_i);
        end
        else
            check("warm_end", {warm_reset_o, core_reset_n_o}, 2'b01);
        @(negedge clk_i);
        check("fetch_pulse", fetch_start_o, 0);
    endtask : reset_case

    initial
    begin
        logic [15:0] cfg;
        int n;
        cfg = 16'($urandom(14449));
        // Power-on reset falls while the clock is still stopped; an initial value gives no edge.
        #2;
        resetn_i = 1'b0;
        #18;
        check("por_core", {core_reset_n_o, reset_out_pin_n_o, warm_reset_o, fetch_start_o}, 0);
        check("por_bus", {bus_hiz_o, config_pullup_o}, 2'b11);
        check("por_cfg", config_latched_o, `AHRS_CFG_PULLED);
        check("por_strobe", strobes_o, 3'b011);
        clk_run = 1'b1;
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        brd.power_up(cfg);
        wait_core(n);
        check("por_release", core_reset_n_o, 1);
        check("por_latch", config_latched_o, cfg);
        // Short pulses, the first just under the filter length, must leave the device running.
        for (int i = 0; i < 4; i++)
        begin
            saw_low = 1'b0;
            brd.pin_low(1'b0, 1'b0, cfg);
            repeat (i == 0 ? `AHRS_FILTER_CYC - 2 : 5 + $urandom_range(50)) @(negedge clk_i);
            brd.pin_high();
            repeat (12) @(negedge clk_i);
            check("glitch_ignored", {saw_low, core_reset_n_o}, 2'b01);
        end
        // A low clock enable freezes the sequencer, so a long pin low while frozen goes unseen.
        saw_low = 1'b0;
        ce_i = 1'b0;
        brd.pin_low(1'b0, 1'b0, cfg);
        repeat (100) @(negedge clk_i);
        brd.pin_high();
        repeat (2) @(negedge clk_i);
        ce_i = 1'b1;
        repeat (12) @(negedge clk_i);
        check("ce_freeze", {saw_low, core_reset_n_o, reset_out_pin_n_o}, 3'b011);
        for (int opt = 0; opt < 8; opt++)
            reset_case(1'b0, 1'b0, {3'(opt), 13'($urandom)}, 80 + int'($urandom_range(60)));
        reset_case(1'b1, 1'b0, cfg, 80);
        reset_case(1'b0, 1'b1, 16'($urandom), 90);
        reset_case(1'b1, 1'b1, cfg, 70 + int'($urandom_range(40)));
        reset_case(1'b0, 1'b1, 16'($urandom), 100);
        summarize();
    end

    // Watchdog well beyond the few thousand cycles the sequence needs.
    initial
    begin
        #(8 * 20000);
        n_fail++;
        summarize();
    end
endmodule : async_hw_reset_sequencer_test
